// [pkg/tmr_pkg.sv]
// Constants for the match-action timer block: widths, register offsets,
// field positions, reset values and bus answers.
// Assumes a 32-bit AXI4-Lite register bus with an 8-bit byte address.
package tmr_pkg;

    // ========================================================================
    // Widths and channel layout
    // ========================================================================
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CNT_W = 16;
    localparam int MODE_W = 3;
    localparam int CH_FIRST = 10;
    localparam int CH_NUM = 10;
    localparam int CH_STRIDE = 3;
    localparam int CTRL_W = 30;
    localparam int FLD_IRQ = 0;
    localparam int FLD_CLEAR = 1;
    localparam int FLD_HALT = 2;
    localparam int RUN_BIT = 0;
    localparam int CNT_RESET_BIT = 1;

    // ========================================================================
    // Register byte offsets
    // ========================================================================
    localparam logic [ADDR_W-1:0] OFF_RUN_CTRL = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_COUNT = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_PRESCALE_CNT = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_PRESCALE_LIM = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MODE = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_ACTION_CTRL = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_MATCH_BASE = 8'h48;
    localparam logic [ADDR_W-1:0] OFF_MATCH_LAST = 8'h6c;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'ha0;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'ha4;

    // ========================================================================
    // Reset values and encodings
    // ========================================================================
    localparam logic [CTRL_W-1:0] RST_ACTION_CTRL = 30'h0;
    localparam logic [CNT_W-1:0] RST_COUNT = 16'h0;
    localparam logic [CNT_W-1:0] RST_PRESCALE_LIM = 16'h0;
    localparam logic [CNT_W-1:0] RST_MATCH = 16'h0;
    localparam logic [MODE_W-1:0] RST_MODE = 3'h0;
    localparam logic [CH_NUM-1:0] RST_STATUS = 10'h0;
    localparam logic [CH_NUM-1:0] RST_MASK = 10'h0;
    localparam logic RST_RUN = 1'b0;
    localparam logic [MODE_W-1:0] MODE_LEVEL = 3'h0;
    localparam logic [MODE_W-1:0] MODE_PULSE = 3'h1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// [pkg/action_if.sv]
// Carrier between the timer core and its match evaluator.
// Assumes both ends sit on the same clock; the evaluator is combinational.
`timescale 1ns/1ps

interface action_if;
    logic [tmr_pkg::CNT_W-1:0] count;
    logic tick;
    logic [tmr_pkg::CH_NUM-1:0][tmr_pkg::CNT_W-1:0] match_value;
    logic [tmr_pkg::CTRL_W-1:0] action_ctrl;
    logic [tmr_pkg::CH_NUM-1:0] hit;
    logic [tmr_pkg::CH_NUM-1:0] irq_event;
    logic halt;
    logic clear;

    modport owner (
        output count, tick, match_value, action_ctrl,
        input hit, irq_event, halt, clear
    );
    modport evaluator (
        input count, tick, match_value, action_ctrl,
        output hit, irq_event, halt, clear
    );
endinterface

// [rtl/match_action_eval.sv]
// Per-channel comparison of match values with the timer count and the
// resulting halt, clear and interrupt events.
// Assumes tick is high for exactly the cycle in which the count advances.
`timescale 1ns/1ps

module match_action_eval (
    // Link to the timer core
    action_if.evaluator act
);

    // ========================================================================
    // Compare and combine actions
    // ========================================================================
    // Halt is collected across all channels so that a halting channel also
    // overrides a clear requested by any other channel on the same count.
    always_comb begin
        logic halt_any;
        logic clear_any;
        halt_any = 1'b0;
        clear_any = 1'b0;
        for (int i = 0; i < tmr_pkg::CH_NUM; i++) begin
            act.hit[i] = act.tick && (act.match_value[i] == act.count);
            act.irq_event[i] = act.hit[i] && act.action_ctrl[tmr_pkg::CH_STRIDE*i + tmr_pkg::FLD_IRQ];
            halt_any = halt_any
                | (act.hit[i] & act.action_ctrl[tmr_pkg::CH_STRIDE*i + tmr_pkg::FLD_HALT]);
            clear_any = clear_any
                | (act.hit[i] & act.action_ctrl[tmr_pkg::CH_STRIDE*i + tmr_pkg::FLD_CLEAR]);
        end
        act.halt = halt_any;
        act.clear = clear_any && !halt_any;
    end

endmodule // match_action_eval

// [rtl/timer_match_action_ctrl_hi.sv]
// 16-bit counter/timer with match actions for channels 10 to 19, behind an
// AXI4-Lite register slave, with sticky per-channel interrupt status.
// Assumes one clock, aclk, and a synchronous active-low reset, aresetn.
//
// Operation
// - Stop enable plus match halts count and prescaler, clears run enable.
// - Reset enable plus match returns the timer count to zero.
// - Interrupt enable plus match raises an interrupt shaped by the mode field.
// - With stop and reset both enabled, only the stop takes effect.
// - Channel k uses bits 3*(k-10) up: interrupt, reset, stop; top at 29.
// - All enables read and write, one enables, reset value zero.
// - The action control register sits at offset 0x18.
// - Each match value is compared with the count on every count step.
`timescale 1ns/1ps

module timer_match_action_ctrl_hi (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address channel
    input wire logic awvalid,
    output logic awready,
    input wire logic [tmr_pkg::ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    // AXI4-Lite write data channel
    input wire logic wvalid,
    output logic wready,
    input wire logic [tmr_pkg::DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response channel
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read address channel
    input wire logic arvalid,
    output logic arready,
    input wire logic [tmr_pkg::ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    // AXI4-Lite read data channel
    output logic rvalid,
    input wire logic rready,
    output logic [tmr_pkg::DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    // Timer state and interrupt
    output logic irq,
    output logic counter_run_enable,
    output logic [tmr_pkg::CNT_W-1:0] timer_count,
    output logic [tmr_pkg::MODE_W-1:0] interrupt_mode_field
);

    // ========================================================================
    // Helper functions
    // ========================================================================
    // Merge a write word into an old value under the byte strobes.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = data[8*b +: 8];
            end
        end
        return res;
    endfunction

    // True when an address hits one of the ten match value registers.
    function automatic logic is_match(input logic [tmr_pkg::ADDR_W-1:0] a);
        return (a >= tmr_pkg::OFF_MATCH_BASE) && (a <= tmr_pkg::OFF_MATCH_LAST) && (a[1:0] == 2'h0);
    endfunction

    // Channel slot of a match value address, 0 for channel 10.
    function automatic logic [3:0] match_slot(input logic [tmr_pkg::ADDR_W-1:0] a);
        logic [tmr_pkg::ADDR_W-1:0] d;
        d = a - tmr_pkg::OFF_MATCH_BASE;
        return d[5:2];
    endfunction

    // True when an address names any implemented register.
    function automatic logic is_mapped(input logic [tmr_pkg::ADDR_W-1:0] a);
        return is_match(a)
            || a == tmr_pkg::OFF_RUN_CTRL || a == tmr_pkg::OFF_COUNT
            || a == tmr_pkg::OFF_PRESCALE_CNT || a == tmr_pkg::OFF_PRESCALE_LIM
            || a == tmr_pkg::OFF_IRQ_MODE || a == tmr_pkg::OFF_ACTION_CTRL
            || a == tmr_pkg::OFF_IRQ_STATUS || a == tmr_pkg::OFF_IRQ_MASK;
    endfunction

    // ========================================================================
    // State
    // ========================================================================
    logic aw_full, next_aw_full;
    logic w_full, next_w_full;
    logic [tmr_pkg::ADDR_W-1:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;

    logic [tmr_pkg::CTRL_W-1:0] action_ctrl, next_action_ctrl;
    logic [tmr_pkg::CH_NUM-1:0][tmr_pkg::CNT_W-1:0] match_value, next_match_value;
    logic [tmr_pkg::CNT_W-1:0] prescale_counter, next_prescale_counter;
    logic [tmr_pkg::CNT_W-1:0] prescale_limit, next_prescale_limit;
    logic [tmr_pkg::CNT_W-1:0] next_timer_count;
    logic next_counter_run_enable;
    logic [tmr_pkg::MODE_W-1:0] next_interrupt_mode_field;
    logic [tmr_pkg::CH_NUM-1:0] irq_status, next_irq_status;
    logic [tmr_pkg::CH_NUM-1:0] irq_mask, next_irq_mask;
    logic next_irq;
    logic do_write;
    logic tick;

    action_if act ();

    // ========================================================================
    // Match evaluator
    // ========================================================================
    match_action_eval u_eval (
        .act(act.evaluator)
    );

    // The count advances when the prescaler wraps while running.
    assign tick = counter_run_enable && (prescale_counter == prescale_limit);

    assign act.count = timer_count;
    assign act.tick = tick;
    assign act.match_value = match_value;
    assign act.action_ctrl = action_ctrl;

    // ========================================================================
    // Bus handshakes
    // ========================================================================
    // Each address or data beat is held until both are present; the slave
    // then refuses further beats until the response has been taken.
    assign awready = !aw_full && !bvalid;
    assign wready = !w_full && !bvalid;
    assign arready = !rvalid;
    assign do_write = aw_full && w_full && !bvalid;

    // ========================================================================
    // Next-state logic
    // ========================================================================
    // One process computes every next value, so the write path, the timer and
    // the status flags all see the same match events of this cycle.
    // The price is a long process; splitting it would duplicate the decoders.
    always_comb begin
        logic [31:0] wv;
        logic [3:0] slot;
        wv = 32'h0;
        slot = 4'h0;

        // Write address and data capture.
        next_aw_full = aw_full;
        next_w_full = w_full;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        if (awvalid && awready) begin
            next_aw_full = 1'b1;
            next_aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            next_w_full = 1'b1;
            next_w_data = wdata;
            next_w_strb = wstrb;
        end

        // Write response.
        next_bvalid = bvalid;
        next_bresp = bresp;
        if (bvalid && bready) begin
            next_bvalid = 1'b0;
        end
        if (do_write) begin
            next_aw_full = 1'b0;
            next_w_full = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = is_mapped(aw_addr) ? tmr_pkg::RESP_OKAY : tmr_pkg::RESP_SLVERR;
        end

        // Timer, prescaler and match actions.
        next_prescale_counter = prescale_counter;
        next_timer_count = timer_count;
        next_counter_run_enable = counter_run_enable;
        if (counter_run_enable) begin
            if (act.halt) begin
                next_counter_run_enable = 1'b0;
            end else if (tick) begin
                next_prescale_counter = tmr_pkg::RST_COUNT;
                if (act.clear) begin
                    next_timer_count = tmr_pkg::RST_COUNT;
                end else begin
                    next_timer_count = timer_count + 16'h1;
                end
            end else begin
                next_prescale_counter = prescale_counter + 16'h1;
            end
        end

        // Register writes; a write steers the timer on the same edge.
        next_action_ctrl = action_ctrl;
        next_match_value = match_value;
        next_prescale_limit = prescale_limit;
        next_interrupt_mode_field = interrupt_mode_field;
        next_irq_mask = irq_mask;
        next_irq_status = irq_status;
        if (do_write) begin
            unique case (aw_addr)
                tmr_pkg::OFF_RUN_CTRL: begin
                    wv = merge({31'h0, counter_run_enable}, w_data, w_strb);
                    // A halt on the same count wins over a software start.
                    if (!act.halt) begin
                        next_counter_run_enable = wv[tmr_pkg::RUN_BIT];
                    end
                    if (wv[tmr_pkg::CNT_RESET_BIT]) begin
                        next_timer_count = tmr_pkg::RST_COUNT;
                        next_prescale_counter = tmr_pkg::RST_COUNT;
                    end
                end
                tmr_pkg::OFF_COUNT: begin
                    wv = merge({16'h0, timer_count}, w_data, w_strb);
                    next_timer_count = wv[tmr_pkg::CNT_W-1:0];
                end
                tmr_pkg::OFF_PRESCALE_LIM: begin
                    wv = merge({16'h0, prescale_limit}, w_data, w_strb);
                    next_prescale_limit = wv[tmr_pkg::CNT_W-1:0];
                end
                tmr_pkg::OFF_IRQ_MODE: begin
                    wv = merge({29'h0, interrupt_mode_field}, w_data, w_strb);
                    next_interrupt_mode_field = wv[tmr_pkg::MODE_W-1:0];
                end
                tmr_pkg::OFF_ACTION_CTRL: begin
                    wv = merge({2'h0, action_ctrl}, w_data, w_strb);
                    next_action_ctrl = wv[tmr_pkg::CTRL_W-1:0];
                end
                tmr_pkg::OFF_IRQ_MASK: begin
                    wv = merge({22'h0, irq_mask}, w_data, w_strb);
                    next_irq_mask = wv[tmr_pkg::CH_NUM-1:0];
                end
                tmr_pkg::OFF_IRQ_STATUS: begin
                    wv = merge(32'h0, w_data, w_strb);
                    next_irq_status = irq_status & ~wv[tmr_pkg::CH_NUM-1:0];
                end
                default: begin
                    if (is_match(aw_addr)) begin
                        slot = match_slot(aw_addr);
                        wv = merge({16'h0, match_value[slot]}, w_data, w_strb);
                        next_match_value[slot] = wv[tmr_pkg::CNT_W-1:0];
                    end
                end
            endcase
        end

        // New events are applied after any clear, so a set always wins.
        next_irq_status = next_irq_status | act.irq_event;
        if (interrupt_mode_field == tmr_pkg::MODE_PULSE) begin
            next_irq = |(act.irq_event & irq_mask);
        end else begin
            next_irq = |(next_irq_status & next_irq_mask);
        end

        // Read channel: one word returned on the edge after the address.
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        if (rvalid && rready) begin
            next_rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            next_rvalid = 1'b1;
            next_rresp = is_mapped(araddr) ? tmr_pkg::RESP_OKAY : tmr_pkg::RESP_SLVERR;
            next_rdata = 32'h0;
            unique case (araddr)
                tmr_pkg::OFF_RUN_CTRL: next_rdata = {31'h0, counter_run_enable};
                tmr_pkg::OFF_COUNT: next_rdata = {16'h0, timer_count};
                tmr_pkg::OFF_PRESCALE_CNT: next_rdata = {16'h0, prescale_counter};
                tmr_pkg::OFF_PRESCALE_LIM: next_rdata = {16'h0, prescale_limit};
                tmr_pkg::OFF_IRQ_MODE: next_rdata = {29'h0, interrupt_mode_field};
                tmr_pkg::OFF_ACTION_CTRL: next_rdata = {2'h0, action_ctrl};
                tmr_pkg::OFF_IRQ_STATUS: next_rdata = {22'h0, irq_status};
                tmr_pkg::OFF_IRQ_MASK: next_rdata = {22'h0, irq_mask};
                default: begin
                    if (is_match(araddr)) begin
                        next_rdata = {16'h0, match_value[match_slot(araddr)]};
                    end
                end
            endcase
        end
    end

    // ========================================================================
    // Registers
    // ========================================================================
    // All enables start cleared so nothing acts on a match after reset.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_addr <= '0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            bvalid <= 1'b0;
            bresp <= tmr_pkg::RESP_OKAY;
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= tmr_pkg::RESP_OKAY;
            action_ctrl <= tmr_pkg::RST_ACTION_CTRL;
            for (int i = 0; i < tmr_pkg::CH_NUM; i++) begin
                match_value[i] <= tmr_pkg::RST_MATCH;
            end
            prescale_counter <= tmr_pkg::RST_COUNT;
            prescale_limit <= tmr_pkg::RST_PRESCALE_LIM;
            timer_count <= tmr_pkg::RST_COUNT;
            counter_run_enable <= tmr_pkg::RST_RUN;
            interrupt_mode_field <= tmr_pkg::RST_MODE;
            irq_status <= tmr_pkg::RST_STATUS;
            irq_mask <= tmr_pkg::RST_MASK;
            irq <= 1'b0;
        end else begin
            aw_full <= next_aw_full;
            w_full <= next_w_full;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
            action_ctrl <= next_action_ctrl;
            match_value <= next_match_value;
            prescale_counter <= next_prescale_counter;
            prescale_limit <= next_prescale_limit;
            timer_count <= next_timer_count;
            counter_run_enable <= next_counter_run_enable;
            interrupt_mode_field <= next_interrupt_mode_field;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            irq <= next_irq;
        end
    end

endmodule // timer_match_action_ctrl_hi

// [dv/tmr_chk.sv]
// Bus and timer checker for the match-action timer, bound to its top module.
// Assumes the register slave timing given by the designer.
`timescale 1ns/1ps

module tmr_chk (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus handshakes
    input wire logic awvalid, awready, wvalid, wready, bvalid, bready,
    input wire logic arvalid, arready, rvalid, rready,
    input wire logic [1:0] bresp,
    input wire logic [31:0] rdata,
    // Timer state
    input wire logic irq, counter_run_enable,
    input wire logic [15:0] timer_count,
    input wire logic [2:0] interrupt_mode_field
);
    // ========================================================================
    // Properties
    // ========================================================================
    // All checks share one clock; reset cycles are not judged.
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence wr_both_s;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence resp_due_s;
        ##2 bvalid;
    endsequence
    wr_lat_a: assert property (wr_both_s |-> resp_due_s) else $error("write answer late");
    rd_lat_a: assert property (arvalid && arready |=> rvalid) else $error("read answer late");
    rd_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("read data moved");
    b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("write answer moved");
    ar_block_a: assert property (rvalid |-> !arready) else $error("read taken while busy");
    aw_block_a: assert property (bvalid |-> !awready && !wready) else $error("write taken while busy");
    // A stopped timer only moves through a committed register write.
    count_hold_a: assert property (!$past(counter_run_enable) && !$rose(bvalid) |-> $stable(timer_count))
        else $error("stopped count moved");
    count_step_a: assert property ($changed(timer_count) && !$rose(bvalid)
        |-> timer_count == $past(timer_count) + 16'h1 || timer_count == 16'h0) else $error("bad count step");
    irq_pulse_a: assert property (interrupt_mode_field == 3'h1 && irq |=> !irq) else $error("pulse too long");
endmodule // tmr_chk

bind timer_match_action_ctrl_hi tmr_chk chk (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid,
    .bready, .arvalid, .arready, .rvalid, .rready, .bresp, .rdata, .irq, .counter_run_enable, .timer_count,
    .interrupt_mode_field);

// [dv/tb.sv]
// Self-checking bench for the match-action timer over AXI4-Lite.
// Assumes a 50 MHz clock and the package offsets of the design.
`timescale 1ns/1ps

module tb;
    // ========================================================================
    // Signals
    // ========================================================================
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, irq, counter_run_enable, irq_seen;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic [15:0] timer_count, mx;
    logic [2:0] interrupt_mode_field;
    int miscompares, checked;
    localparam logic [1:0] OK = tmr_pkg::RESP_OKAY;
    localparam logic [1:0] ERR = tmr_pkg::RESP_SLVERR;
    localparam logic [7:0] CTRL = tmr_pkg::OFF_ACTION_CTRL;
    localparam logic [7:0] RUN = tmr_pkg::OFF_RUN_CTRL;
    localparam logic [7:0] STAT = tmr_pkg::OFF_IRQ_STATUS;
    localparam logic [7:0] MASK = tmr_pkg::OFF_IRQ_MASK;

    timer_match_action_ctrl_hi dut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid,
        .wready, .wdata, .wstrb(4'hf), .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0),
        .rvalid, .rready, .rdata, .rresp, .irq, .counter_run_enable, .timer_count, .interrupt_mode_field);

    // ========================================================================
    // Shared tasks
    // ========================================================================
    task automatic test_done;
        $display("miscompares=%0d checked=%0d", miscompares, checked);
        if (miscompares == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic timeout;
        miscompares++;
        test_done;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Ready is sampled at the falling edge, so it is the value the next rising edge sees.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic pa, pw, hb;
        logic [1:0] r;
        int n;
        pa = 1;
        pw = 1;
        hb = 0;
        @(posedge aclk);
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1;
        for (n = 0; n < 50 && (pa || pw); n++) begin
            @(negedge aclk); if (awready) pa = 0; if (wready) pw = 0;
            @(posedge aclk); if (!pa) awvalid <= 0; if (!pw) wvalid <= 0;
        end
        // Ready comes two edges late so that the answer must stand while it waits.
        repeat (2) @(posedge aclk);
        bready <= 1;
        while (n < 100 && !hb) begin
            @(negedge aclk);
            hb = bvalid;
            r = bresp;
            @(posedge aclk);
            n++;
        end
        bready <= 0;
        if (!hb) timeout;
        check(r, er);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ha, hr;
        logic [31:0] d;
        logic [1:0] r;
        int n;
        ha = 0;
        hr = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1;
        for (n = 0; n < 50 && !ha; n++) begin
            @(negedge aclk); ha = arready;
            @(posedge aclk); if (ha) arvalid <= 0;
        end
        // Ready comes one edge late so that the read data must stand while it waits.
        @(posedge aclk);
        rready <= 1;
        while (n < 100 && !hr) begin
            @(negedge aclk);
            hr = rvalid;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            n++;
        end
        rready <= 0;
        if (!hr) timeout;
        check(d, ed);
        check(r, er);
    endtask
    // Watches the count and irq; mode 1 stops on a halt, mode 2 on irq.
    task automatic watch(input int cyc, input int mode);
        logic hit;
        int n;
        hit = 0;
        mx = 0;
        irq_seen = 0;
        for (n = 0; n < cyc && !hit; n++) begin
            @(negedge aclk);
            if (timer_count > mx) mx = timer_count;
            if (irq === 1'b1) irq_seen = 1;
            hit = (mode == 1 && counter_run_enable === 1'b0) || (mode == 2 && irq === 1'b1);
        end
        if (mode != 0 && !hit) timeout;
    endtask

    // ========================================================================
    // Scenarios
    // ========================================================================
    task automatic t_regs;
        rd(CTRL, 32'h0, OK);
        wr(CTRL, 32'hffffffff, OK);
        rd(CTRL, 32'h3fffffff, OK);
        for (int i = 0; i < 30; i++) begin
            wr(CTRL, 32'h1 << i, OK);
            rd(CTRL, 32'h1 << i, OK);
        end
        rd(8'hfc, 32'h0, ERR);
        wr(8'hfc, 32'h1, ERR);
    endtask
    task automatic t_halt;
        wr(8'h6c, 32'h5, OK);
        wr(CTRL, 32'h30000000, OK);
        wr(RUN, 32'h3, OK);
        watch(100, 1);
        check(timer_count, 32'h5);
        check(counter_run_enable, 32'h0);
        watch(10, 0);
        check(mx, 32'h5);
    endtask
    task automatic t_clear;
        wr(CTRL, 32'h2, OK);
        wr(8'h48, 32'h3, OK);
        wr(RUN, 32'h3, OK);
        watch(40, 0);
        check(mx, 32'h3);
        wr(RUN, 32'h0, OK);
    endtask
    task automatic t_irq;
        wr(CTRL, 32'h3000, OK);
        wr(8'h58, 32'h2, OK);
        wr(MASK, 32'h10, OK);
        wr(RUN, 32'h3, OK);
        watch(40, 2);
        wr(RUN, 32'h0, OK);
        rd(STAT, 32'h10, OK);
        check(irq, 32'h1);
        wr(STAT, 32'h10, OK);
        rd(STAT, 32'h0, OK);
        check(irq, 32'h0);
        wr(MASK, 32'h0, OK);
        wr(RUN, 32'h3, OK);
        watch(30, 0);
        check(irq_seen, 32'h0);
        wr(RUN, 32'h0, OK);
        wr(STAT, 32'h3ff, OK);
        wr(8'h14, 32'h1, OK);
        check(interrupt_mode_field, 32'h1);
        wr(MASK, 32'h10, OK);
        wr(RUN, 32'h3, OK);
        watch(40, 2);
        @(negedge aclk);
        check(irq, 32'h0);
        wr(CTRL, 32'h2000, OK);
        wr(STAT, 32'h3ff, OK);
        watch(20, 0);
        wr(RUN, 32'h0, OK);
        rd(STAT, 32'h0, OK);
    endtask

    // ========================================================================
    // Clock and main sequence
    // ========================================================================
    initial begin
        aclk = 0;
        forever #10 aclk = ~aclk;
    end
    initial begin
        aresetn = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
        awaddr = 0; araddr = 0; wdata = 0; miscompares = 0; checked = 0;
        repeat (10) @(posedge aclk);
        aresetn <= 1;
        t_regs;
        t_halt;
        t_clear;
        t_irq;
        test_done;
    end
endmodule // tb
